//--- core/etc_top.sv
// Eight-bit timer/counter with AXI4-Lite registers, interrupt and gate output
`timescale 1ns/1ps
module etc_top #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inst_cycle_en,
	input wire logic external_count_pin,
	input wire logic gate_pin,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic overflow_out,
	output logic timer1_gate,
	output logic irq
);
	// Decoder reads address bits 7:2, so a narrower bus cannot reach every register
	if (ADDR_W < 8) begin : g_addr_w_check
		$error("ADDR_W must be at least 8");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction : hit

	// Pin synchronisers
	logic [1:0] pin_sync_r, pin_sync_nxt;
	logic [1:0] gpin_sync_r, gpin_sync_nxt;
	logic pin_prev_r, pin_prev_nxt;
	// Bus state
	logic [ADDR_W-1:0] aw_r, aw_nxt;
	logic aw_have_r, aw_have_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic w_have_r, w_have_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic arready_r, arready_nxt;
	// Timer state
	logic [7:0] count_r, count_nxt;
	logic [7:0] presc_r, presc_nxt;
	etc_pkg::etc_opt_t opt_r, opt_nxt;
	logic [1:0] hold_r, hold_nxt;
	logic status_r, status_nxt;
	logic mask_r, mask_nxt;
	logic [1:0] gss_r, gss_nxt;
	logic ovf_r, ovf_nxt;
	logic gate_r, gate_nxt;
	logic irq_r, irq_nxt;

	logic do_write, pin_edge, tick, presc_out, inc, wr_count;
	logic [7:0] wbyte;

	always_comb begin
		pin_sync_nxt = {pin_sync_r[0], external_count_pin};
		gpin_sync_nxt = {gpin_sync_r[0], gate_pin};
		// Edge flop idles low like the pin, so reset gives no false edge
		pin_prev_nxt = pin_sync_r[1];
	end

	always_comb begin
		// Waits for a pending response; a new address may be taken meanwhile
		do_write = aw_have_r && w_have_r && !bvalid_r;
		wbyte = ws_r[0] ? wd_r[7:0] : 8'h00;
		aw_nxt = aw_r;
		aw_have_nxt = aw_have_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		w_have_nxt = w_have_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = s_axi_awaddr;
			aw_have_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
			w_have_nxt = 1'b1;
		end
		if (do_write) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (hit(aw_r, etc_pkg::ADDR_COUNT) || hit(aw_r, etc_pkg::ADDR_OPTION)
				|| hit(aw_r, etc_pkg::ADDR_STATUS) || hit(aw_r, etc_pkg::ADDR_MASK)
				|| hit(aw_r, etc_pkg::ADDR_GATE)) ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		// Ready stays low while a held address or word waits for its partner
		awready_nxt = !aw_have_nxt;
		wready_nxt = !w_have_nxt;
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = etc_pkg::RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (hit(s_axi_araddr, etc_pkg::ADDR_COUNT)) begin
				rdata_nxt[7:0] = count_r;
			end else if (hit(s_axi_araddr, etc_pkg::ADDR_OPTION)) begin
				rdata_nxt[etc_pkg::OPT_PS_LSB +: 3] = opt_r.ps;
				rdata_nxt[etc_pkg::OPT_PSA_BIT] = opt_r.psa;
				rdata_nxt[etc_pkg::OPT_EDGE_BIT] = opt_r.edge_sel;
				rdata_nxt[etc_pkg::OPT_SRC_BIT] = opt_r.src_sel;
			end else if (hit(s_axi_araddr, etc_pkg::ADDR_STATUS)) begin
				rdata_nxt[0] = status_r;
			end else if (hit(s_axi_araddr, etc_pkg::ADDR_MASK)) begin
				rdata_nxt[0] = mask_r;
			end else if (hit(s_axi_araddr, etc_pkg::ADDR_GATE)) begin
				rdata_nxt[1:0] = gss_r;
			end else begin
				rresp_nxt = etc_pkg::RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_comb begin
		wr_count = do_write && ws_r[0] && hit(aw_r, etc_pkg::ADDR_COUNT);
		// Edge select 0 counts rising edges, 1 falling
		pin_edge = opt_r.edge_sel ? (pin_prev_r && !pin_sync_r[1])
			: (!pin_prev_r && pin_sync_r[1]);
		// Source select picks pin edges or instruction cycles
		tick = opt_r.src_sel ? pin_edge : inc_cycle(inst_cycle_en);
		presc_nxt = presc_r;
		presc_out = tick;
		if (opt_r.psa == 1'b0 && tick) begin
			// Private prescaler, divide by 2^(ps+1)
			presc_nxt = presc_r + 8'h01;
			presc_out = (presc_nxt & ((8'h02 << opt_r.ps) - 8'h01)) == 8'h00;
		end
		// Holdoff runs on instruction cycles in either source mode
		hold_nxt = hold_r;
		if (inst_cycle_en && hold_r != 2'h0) begin
			hold_nxt = hold_r - 2'h1;
		end
		inc = presc_out && (hold_r == 2'h0);
		count_nxt = count_r;
		ovf_nxt = 1'b0;
		opt_nxt = opt_r;
		gss_nxt = gss_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		if (wr_count) begin
			count_nxt = wbyte;
			hold_nxt = etc_pkg::HOLDOFF_CYCLES;
			presc_nxt = 8'h00;
		end else if (inc) begin
			count_nxt = count_r + 8'h01;
			ovf_nxt = (count_r == 8'hFF);
		end
		if (do_write && ws_r[0]) begin
			if (hit(aw_r, etc_pkg::ADDR_OPTION)) begin
				opt_nxt.ps = wbyte[etc_pkg::OPT_PS_LSB +: 3];
				opt_nxt.psa = wbyte[etc_pkg::OPT_PSA_BIT];
				opt_nxt.edge_sel = wbyte[etc_pkg::OPT_EDGE_BIT];
				opt_nxt.src_sel = wbyte[etc_pkg::OPT_SRC_BIT];
				// A new rate starts from a clean division
				presc_nxt = 8'h00;
			end
			if (hit(aw_r, etc_pkg::ADDR_GATE)) begin
				gss_nxt = wbyte[1:0];
			end
			if (hit(aw_r, etc_pkg::ADDR_MASK)) begin
				mask_nxt = wbyte[0];
			end
			if (hit(aw_r, etc_pkg::ADDR_STATUS) && wbyte[0]) begin
				status_nxt = 1'b0;
			end
		end
		// Set beats clear in the same cycle
		if (ovf_nxt) begin
			status_nxt = 1'b1;
		end
		gate_nxt = (gss_r == etc_pkg::GATE_SRC_OVF) ? ovf_r : gpin_sync_r[1];
		irq_nxt = status_nxt && mask_nxt;
	end

	function automatic logic inc_cycle(input logic en);
		inc_cycle = en;
	endfunction : inc_cycle

	// Pin synchroniser registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_sync_r <= 2'b00;
			gpin_sync_r <= 2'b00;
			pin_prev_r <= 1'b0;
		end else begin
			pin_sync_r <= pin_sync_nxt;
			gpin_sync_r <= gpin_sync_nxt;
			pin_prev_r <= pin_prev_nxt;
		end
	end

	// Write channel registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_r <= '0;
			aw_have_r <= 1'b0;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			w_have_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= etc_pkg::RESP_OKAY;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
		end else begin
			aw_r <= aw_nxt;
			aw_have_r <= aw_have_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			w_have_r <= w_have_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
		end
	end

	// Read channel registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= etc_pkg::RESP_OKAY;
			arready_r <= 1'b1;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			arready_r <= arready_nxt;
		end
	end

	// Timer registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r <= etc_pkg::COUNT_RESET;
			presc_r <= 8'h00;
			opt_r <= etc_pkg::OPTION_RESET[5:0];
			hold_r <= 2'h0;
			status_r <= 1'b0;
			mask_r <= 1'b0;
			gss_r <= 2'h0;
			ovf_r <= 1'b0;
			gate_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			presc_r <= presc_nxt;
			opt_r <= opt_nxt;
			hold_r <= hold_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			gss_r <= gss_nxt;
			ovf_r <= ovf_nxt;
			gate_r <= gate_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Ready flags have flops of their own, so no port leaves through a gate
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_arready = arready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign overflow_out = ovf_r;
	assign timer1_gate = gate_r;
	assign irq = irq_r;
endmodule : etc_top

//--- core/etc_pkg.sv
// Package for the eight-bit timer/counter: register map, fields, reset values
// Operation
// - Count lives in one 8-bit register that software reads and writes.
// - An 8-bit prescaler, private to this timer, sits ahead of the count.
// - Timer mode without prescaler adds one every instruction cycle.
// - Source select cleared means timer mode on instruction cycles.
// - After a count write, two instruction cycles pass without increment.
// - Counter mode adds one on each selected edge of the external pin; with psa cleared the prescaler divides the edges first.
// - Source select set to 1 means counting the external pin.
// - Edge select picks rising or falling pin edges.
// - Overflow is exported for use as the second timer's gate.
// - Gate source select equal to 01 routes overflow to second timer gate.
package etc_pkg;
	localparam logic [7:0] ADDR_COUNT = 8'h00;
	localparam logic [7:0] ADDR_OPTION = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_GATE = 8'h10;
	localparam int OPT_SRC_BIT = 0;
	localparam int OPT_EDGE_BIT = 1;
	localparam int OPT_PSA_BIT = 2;
	localparam int OPT_PS_LSB = 4;
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] GATE_SRC_OVF = 2'h1;
	localparam logic [1:0] HOLDOFF_CYCLES = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [2:0] ps;
		logic psa;
		logic edge_sel;
		logic src_sel;
	} etc_opt_t;
endpackage : etc_pkg

//--- tb/etc_properties.sv
// Bus handshake and overflow checker for the timer/counter
`timescale 1ns/1ps
module etc_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic overflow_out,
	input wire logic timer1_gate,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ovf_pulse: assert property (overflow_out |=> !overflow_out)
		else $error("long overflow pulse");
	a_b_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	a_aw_shut: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready after take");
	a_w_shut: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("data ready after take");
	a_ready_back: assert property (
		s_axi_bvalid && s_axi_bready && s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid
		|=> s_axi_awready && s_axi_wready)
		else $error("write ready lost");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data");
	a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	a_ar_shut: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready early");
	c_ovf: cover property (overflow_out);
	c_irq: cover property (irq);
	c_gate: cover property (timer1_gate);
endmodule : etc_properties

bind etc_top etc_properties i_props (.*);

//--- tb/etc_pin_src.sv
// Edge source standing in for the external count pin
`timescale 1ns/1ps
module etc_pin_src (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;
	// Pin stands still between steps
	task automatic step(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			pin <= ~pin;
		end
	endtask : step
endmodule : etc_pin_src

//--- tb/eight_bit_timer_counter_bench.sv
// Self-checking bench for the eight-bit timer/counter
`timescale 1ns/1ps
module eight_bit_timer_counter_bench;
	logic clk = 1'b0, rst_n = 1'b0, ice = 1'b0, gpin = 1'b0, awv = 1'b0;
	logic wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0] aa = 8'h00, ra = 8'h00;
	logic [31:0] wd = 32'h0000_0000, rdd;
	logic awr, wrd, bv, arr, rv, ovf, gate, irq, pin;
	logic [1:0] br, rr, wresp;
	int mismatches = 0, checks = 0, novf = 0, ngate = 0;
	etc_top i_dut (.clk(clk), .rst_n(rst_n), .inst_cycle_en(ice), .external_count_pin(pin), .gate_pin(gpin),
		.s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .overflow_out(ovf), .timer1_gate(gate), .irq(irq));
	etc_pin_src i_src (.clk(clk), .pin(pin));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		novf <= novf + int'(ovf === 1'b1);
		ngate <= ngate + int'(gate === 1'b1);
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		aa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		forever begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		wresp = br;
		bry <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		ra <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		forever begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rry <= 1'b0;
		chk(rdd, {24'h00_0000, e});
		chk(32'(rr), 32'(er));
	endtask : rc
	// Instruction-cycle pulses, then settling time
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			ice <= 1'b1;
			@(posedge clk);
			ice <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask : tick
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	initial begin
		#100000;
		mismatches++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rc(8'h00, 8'h00, 2'h0);
		rc(8'h04, 8'h00, 2'h0);
		rc(8'h14, 8'h00, etc_pkg::RESP_SLVERR);
		wr(8'h14, 32'h0000_00ff);
		chk(32'(wresp), 32'(etc_pkg::RESP_SLVERR));
		$display("test reset done");
		wr(8'h04, 32'h0000_0004);
		chk(32'(wresp), 32'(etc_pkg::RESP_OKAY));
		wr(8'h00, 32'h0000_0010);
		tick(5);
		rc(8'h00, 8'h13, 2'h0);
		$display("test timer done");
		for (int r = 0; r < 3; r++) begin
			wr(8'h04, 32'(r << 4));
			wr(8'h00, 32'h0000_0000);
			tick(18);
			rc(8'h00, 8'(16 >> (r + 1)), 2'h0);
		end
		$display("test prescaler done");
		wr(8'h00, 32'h0000_0020);
		tick(2);
		for (int e = 0; e < 2; e++) begin
			wr(8'h04, 32'(5 + 2 * e));
			i_src.step(1);
			tick(0);
			rc(8'h00, 8'h21, 2'h0);
			i_src.step(1);
			tick(0);
			rc(8'h00, 8'(33 + e), 2'h0);
		end
		$display("test counter done");
		wr(8'h04, 32'h0000_0004);
		wr(8'h0c, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001);
		wr(8'h00, 32'h0000_00fe);
		tick(4);
		chk(32'(novf), 32'h0000_0001);
		chk(32'(ngate), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		rc(8'h08, 8'h01, 2'h0);
		wr(8'h08, 32'h0000_0001);
		rc(8'h08, 8'h00, 2'h0);
		chk(32'(irq), 32'h0000_0000);
		wr(8'h0c, 32'h0000_0000);
		wr(8'h10, 32'h0000_0000);
		wr(8'h00, 32'h0000_00fe);
		tick(4);
		chk(32'(novf), 32'h0000_0002);
		chk(32'(ngate), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		gpin <= 1'b1;
		tick(0);
		chk(32'(gate), 32'h0000_0001);
		$display("test overflow done");
		close_out();
	end
endmodule : eight_bit_timer_counter_bench
